// *** memory_map_pkg.sv ***
// Constants and types shared by the on-chip memory map and arbiter.
// Summary of operation
// - Fetch, operand read and operand write are all accepted in one machine cycle when no two of them hit one single RAM block.
// - Program, local data, I/O and global data spaces are decoded separately.
// - Setting the ROM map select bit removes the boot ROM from program space.
// - A low ROM select pin at reset maps the ROM, otherwise execution starts off-chip.
// - Dual RAM holds block zero 512, block one 512, block two 32 words.
// - Dual blocks one and two stay in data space; only block zero moves.
// - Dual RAM is 1056 data words, or 544 data plus 512 program words.
// - Dual RAM serves one read and one write per cycle without stalling.
// - Single RAM may sit in data space, program space, or both.
// - Single RAM is contiguous 1K or 2K blocks, accessed in parallel.
// - Each single RAM block serves at most one access per cycle.
// - Colliding single block accesses raise not-ready and run one per cycle; core holds.
// - Fetch and data access to one shared single block take two cycles.
// - With protection set, externally fetched instructions cannot touch on-chip memory.
package memory_map_pkg;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [3:0] MODE_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int MODE_ROM_MAP_BIT = 0;
  localparam int MODE_B0_PROG_BIT = 1;
  localparam int MODE_SA_DATA_BIT = 2;
  localparam int MODE_SA_PROG_BIT = 3;
  localparam int MODE_PROTECT_BIT = 4;
  localparam int MODE_WIDTH = 5;
  localparam logic [4:0] MODE_RESET = 5'h05;
  localparam int STATUS_BLOCKED_BIT = 0;
  localparam int STATUS_NOT_READY_BIT = 1;
  localparam int STATUS_STRAP_BIT = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [15:0] ROM_BASE = 16'h0000;
  localparam logic [15:0] B2_BASE = 16'h0060;
  localparam logic [15:0] B0_DATA_BASE = 16'h0100;
  localparam logic [15:0] B1_BASE = 16'h0300;
  localparam logic [15:0] B1_END = 16'h0500;
  localparam logic [15:0] B0_PROG_BASE = 16'hfe00;
  localparam logic [15:0] SINGLE_ACCESS_RAM_BASE = 16'h0800;
  localparam logic [15:0] B2_WORDS = 16'h0020;
  localparam logic [15:0] B1_INDEX = 16'h0200;
  localparam logic [15:0] B2_INDEX = 16'h0400;
  localparam int DUAL_WORDS = 1056;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPACE_PROGRAM = 2'b00,
    SPACE_LOCAL_DATA = 2'b01,
    SPACE_IO = 2'b10,
    SPACE_GLOBAL_DATA = 2'b11
  } space_t;

  typedef enum logic [1:0] {
    TGT_OFF_CHIP = 2'b00,
    TGT_ROM = 2'b01,
    TGT_DUAL = 2'b10,
    TGT_SINGLE = 2'b11
  } target_t;

  localparam int REQ_WRITE = 0;
  localparam int REQ_READ = 1;
  localparam int REQ_FETCH = 2;

endpackage

// *** on_chip_memory_map_arbiter.sv ***
// On-chip ROM, dual and single access RAM with map decode and access scheduling.
`timescale 1ns/10ps
module on_chip_memory_map_arbiter #(
  parameter int ROM_WORDS = 2048,
  parameter logic [15:0] ROM_FILL = 16'h0000,
  parameter int SINGLE_ACCESS_RAM_BLOCKS = 2,
  parameter int SINGLE_ACCESS_RAM_BLOCK_WORDS = 1024
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic ROM_SELECT_N,
  input wire logic FETCH_REQ,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic READ_REQ,
  input wire logic [1:0] READ_SPACE,
  input wire logic [15:0] READ_ADDR,
  input wire logic WRITE_REQ,
  input wire logic [1:0] WRITE_SPACE,
  input wire logic [15:0] WRITE_ADDR,
  input wire logic [15:0] WRITE_DATA,
  input wire logic EXTERNAL_ORIGIN,
  output logic NOT_READY,
  output logic ACCESS_DONE,
  output logic [15:0] FETCH_DATA,
  output logic FETCH_ON_CHIP,
  output logic [15:0] READ_DATA,
  output logic READ_ON_CHIP,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  localparam int SA_WORDS = SINGLE_ACCESS_RAM_BLOCKS * SINGLE_ACCESS_RAM_BLOCK_WORDS;
  localparam int SA_AW = $clog2(SA_WORDS);
  localparam int BLK_AW = $clog2(SINGLE_ACCESS_RAM_BLOCK_WORDS);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic in_single(input logic [15:0] a);
    logic [15:0] off;
    off = a - memory_map_pkg::SINGLE_ACCESS_RAM_BASE;
    return (a >= memory_map_pkg::SINGLE_ACCESS_RAM_BASE) && ({1'b0, off} < 17'(SA_WORDS));
  endfunction

  function automatic memory_map_pkg::target_t decode(input logic [1:0] space, input logic [15:0] a,
                                                      input logic [4:0] m);
    memory_map_pkg::target_t t;
    t = memory_map_pkg::TGT_OFF_CHIP;
    // I/O and global data spaces never land on chip
    if (space == memory_map_pkg::SPACE_PROGRAM) begin
      if (!m[memory_map_pkg::MODE_ROM_MAP_BIT] && {1'b0, a} < 17'(ROM_WORDS)) begin
        t = memory_map_pkg::TGT_ROM;
      end else if (m[memory_map_pkg::MODE_B0_PROG_BIT] && a >= memory_map_pkg::B0_PROG_BASE) begin
        t = memory_map_pkg::TGT_DUAL;
      end else if (m[memory_map_pkg::MODE_SA_PROG_BIT] && in_single(a)) begin
        t = memory_map_pkg::TGT_SINGLE;
      end
    end else if (space == memory_map_pkg::SPACE_LOCAL_DATA) begin
      if (a >= memory_map_pkg::B2_BASE && a < memory_map_pkg::B2_BASE + memory_map_pkg::B2_WORDS) begin
        t = memory_map_pkg::TGT_DUAL;
      end else if (a >= memory_map_pkg::B1_BASE && a < memory_map_pkg::B1_END) begin
        t = memory_map_pkg::TGT_DUAL;
      end else if (!m[memory_map_pkg::MODE_B0_PROG_BIT] && a >= memory_map_pkg::B0_DATA_BASE &&
                   a < memory_map_pkg::B1_BASE) begin
        t = memory_map_pkg::TGT_DUAL;
      end else if (m[memory_map_pkg::MODE_SA_DATA_BIT] && in_single(a)) begin
        t = memory_map_pkg::TGT_SINGLE;
      end
    end
    return t;
  endfunction

  // Block zero, block one, block two laid end to end in one array
  function automatic logic [10:0] dual_index(input logic [1:0] space, input logic [15:0] a);
    logic [15:0] d;
    if (space == memory_map_pkg::SPACE_PROGRAM) begin
      d = a - memory_map_pkg::B0_PROG_BASE;
    end else if (a < memory_map_pkg::B0_DATA_BASE) begin
      d = a - memory_map_pkg::B2_BASE + memory_map_pkg::B2_INDEX;
    end else if (a < memory_map_pkg::B1_BASE) begin
      d = a - memory_map_pkg::B0_DATA_BASE;
    end else begin
      d = a - memory_map_pkg::B1_BASE + memory_map_pkg::B1_INDEX;
    end
    return d[10:0];
  endfunction

  function automatic logic [SA_AW-1:0] single_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - memory_map_pkg::SINGLE_ACCESS_RAM_BASE;
    return d[SA_AW-1:0];
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Memories carry no reset; only their control is reset
  logic [15:0] dual_ram [0:memory_map_pkg::DUAL_WORDS-1];
  logic [15:0] single_ram [0:SA_WORDS-1];

  logic [4:0] mode;
  logic [4:0] next_mode;
  logic blocked_flag;
  logic next_blocked_flag;
  logic [1:0] strap_count;
  logic [1:0] next_strap_count;
  logic strap_meta;
  logic strap_sync;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;

  logic [2:0] valid;
  logic [2:0] done;
  logic [2:0] next_done;
  logic [2:0] pending;
  logic [2:0] grant;
  logic [2:0] blocked;
  logic [1:0] space [0:2];
  logic [15:0] addr [0:2];
  memory_map_pkg::target_t kind [0:2];
  logic [SA_AW-1:0] sidx [0:2];
  logic [10:0] didx [0:2];
  logic stall;
  logic [15:0] next_fetch_data;
  logic next_fetch_on_chip;
  logic [15:0] next_read_data;
  logic next_read_on_chip;
  logic next_access_done;

  // ----------------------------------------
  // Request decode and scheduling
  // ----------------------------------------
  always_comb begin
    valid = {FETCH_REQ, READ_REQ, WRITE_REQ};
    space[memory_map_pkg::REQ_WRITE] = WRITE_SPACE;
    space[memory_map_pkg::REQ_READ] = READ_SPACE;
    space[memory_map_pkg::REQ_FETCH] = memory_map_pkg::SPACE_PROGRAM;
    addr[memory_map_pkg::REQ_WRITE] = WRITE_ADDR;
    addr[memory_map_pkg::REQ_READ] = READ_ADDR;
    addr[memory_map_pkg::REQ_FETCH] = FETCH_ADDR;
    for (int r = 0; r < 3; r++) begin
      kind[r] = decode(space[r], addr[r], mode);
      sidx[r] = single_index(addr[r]);
      didx[r] = dual_index(space[r], addr[r]);
      pending[r] = valid[r] && !done[r];
      // Protection stops data moves issued by code running from off-chip memory
      blocked[r] = mode[memory_map_pkg::MODE_PROTECT_BIT] && EXTERNAL_ORIGIN &&
                   kind[r] != memory_map_pkg::TGT_OFF_CHIP && r != memory_map_pkg::REQ_FETCH;
    end
    for (int r = 0; r < 3; r++) begin
      grant[r] = pending[r];
      if (kind[r] == memory_map_pkg::TGT_SINGLE && !blocked[r]) begin
        for (int q = 0; q < r; q++) begin
          // Lower index has priority: write, read, fetch
          if (pending[q] && kind[q] == memory_map_pkg::TGT_SINGLE && !blocked[q] &&
              sidx[q][SA_AW-1:BLK_AW] == sidx[r][SA_AW-1:BLK_AW]) begin
            grant[r] = 1'b0;
          end
        end
      end
    end
    // Dual RAM never collides, so a read beside a write in it is granted at once
    stall = |(pending & ~grant);
    // Served requests stay marked while the core holds the rest
    next_done = stall ? (done | grant) : 3'h0;
    next_access_done = (|valid) && !stall;
  end

  always_comb begin
    next_fetch_data = FETCH_DATA;
    next_fetch_on_chip = FETCH_ON_CHIP;
    next_read_data = READ_DATA;
    next_read_on_chip = READ_ON_CHIP;
    if (grant[memory_map_pkg::REQ_FETCH]) begin
      next_fetch_on_chip = kind[memory_map_pkg::REQ_FETCH] != memory_map_pkg::TGT_OFF_CHIP;
      unique case (kind[memory_map_pkg::REQ_FETCH])
        memory_map_pkg::TGT_ROM: next_fetch_data = ROM_FILL;
        memory_map_pkg::TGT_DUAL: next_fetch_data = dual_ram[didx[memory_map_pkg::REQ_FETCH]];
        memory_map_pkg::TGT_SINGLE: next_fetch_data = single_ram[sidx[memory_map_pkg::REQ_FETCH]];
        memory_map_pkg::TGT_OFF_CHIP: next_fetch_data = 16'h0000;
      endcase
    end
    if (grant[memory_map_pkg::REQ_READ]) begin
      next_read_on_chip = kind[memory_map_pkg::REQ_READ] != memory_map_pkg::TGT_OFF_CHIP &&
                          !blocked[memory_map_pkg::REQ_READ];
      next_read_data = 16'h0000;
      if (!blocked[memory_map_pkg::REQ_READ]) begin
        // A read beside a write to the same dual RAM word returns the old word; in single RAM the write goes first
        unique case (kind[memory_map_pkg::REQ_READ])
          memory_map_pkg::TGT_ROM: next_read_data = ROM_FILL;
          memory_map_pkg::TGT_DUAL: next_read_data = dual_ram[didx[memory_map_pkg::REQ_READ]];
          memory_map_pkg::TGT_SINGLE: next_read_data = single_ram[sidx[memory_map_pkg::REQ_READ]];
          memory_map_pkg::TGT_OFF_CHIP: next_read_data = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      done <= 3'h0;
      NOT_READY <= 1'b0;
      ACCESS_DONE <= 1'b0;
      FETCH_DATA <= 16'h0000;
      FETCH_ON_CHIP <= 1'b0;
      READ_DATA <= 16'h0000;
      READ_ON_CHIP <= 1'b0;
    end else begin
      done <= next_done;
      NOT_READY <= stall;
      ACCESS_DONE <= next_access_done;
      FETCH_DATA <= next_fetch_data;
      FETCH_ON_CHIP <= next_fetch_on_chip;
      READ_DATA <= next_read_data;
      READ_ON_CHIP <= next_read_on_chip;
    end
  end

  // ----------------------------------------
  // Memory write port
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (grant[memory_map_pkg::REQ_WRITE] && !blocked[memory_map_pkg::REQ_WRITE]) begin
      if (kind[memory_map_pkg::REQ_WRITE] == memory_map_pkg::TGT_DUAL) begin
        dual_ram[didx[memory_map_pkg::REQ_WRITE]] <= WRITE_DATA;
      end else if (kind[memory_map_pkg::REQ_WRITE] == memory_map_pkg::TGT_SINGLE) begin
        single_ram[sidx[memory_map_pkg::REQ_WRITE]] <= WRITE_DATA;
      end
    end
  end

  // ----------------------------------------
  // Register bus and reset strap
  // ----------------------------------------
  always_comb begin
    next_ack = (AVS_READ || AVS_WRITE) && !ack;
    next_mode = mode;
    next_strap_count = strap_count;
    next_readdata = AVS_READDATA;
    if (AVS_WRITE && ack && AVS_BYTEENABLE[0] && AVS_ADDRESS == memory_map_pkg::MODE_OFFSET) begin
      next_mode = AVS_WRITEDATA[memory_map_pkg::MODE_WIDTH-1:0];
    end
    // Pin is sampled once the synchroniser has settled after reset release
    if (strap_count != memory_map_pkg::STRAP_SETTLE) begin
      next_strap_count = strap_count + 2'h1;
      if (next_strap_count == memory_map_pkg::STRAP_SETTLE) begin
        next_mode[memory_map_pkg::MODE_ROM_MAP_BIT] = strap_sync;
      end
    end
    // Set wins over a clear in the same cycle
    next_blocked_flag = blocked_flag;
    if (AVS_WRITE && ack && AVS_BYTEENABLE[0] && AVS_ADDRESS == memory_map_pkg::STATUS_OFFSET &&
        AVS_WRITEDATA[memory_map_pkg::STATUS_BLOCKED_BIT]) begin
      next_blocked_flag = 1'b0;
    end
    if (|(grant & blocked)) begin
      next_blocked_flag = 1'b1;
    end
    if (AVS_READ && !ack) begin
      next_readdata = 32'h0000_0000;
      if (AVS_ADDRESS == memory_map_pkg::MODE_OFFSET) begin
        next_readdata[memory_map_pkg::MODE_WIDTH-1:0] = mode;
      end else if (AVS_ADDRESS == memory_map_pkg::STATUS_OFFSET) begin
        next_readdata[memory_map_pkg::STATUS_BLOCKED_BIT] = blocked_flag;
        next_readdata[memory_map_pkg::STATUS_NOT_READY_BIT] = stall;
        next_readdata[memory_map_pkg::STATUS_STRAP_BIT] = strap_sync;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      strap_meta <= 1'b1;
      strap_sync <= 1'b1;
      strap_count <= 2'h0;
      mode <= memory_map_pkg::MODE_RESET;
      blocked_flag <= 1'b0;
      ack <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      strap_meta <= ROM_SELECT_N;
      strap_sync <= strap_meta;
      strap_count <= next_strap_count;
      mode <= next_mode;
      blocked_flag <= next_blocked_flag;
      ack <= next_ack;
      AVS_READDATA <= next_readdata;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;

endmodule

// *** on_chip_memory_map_arbiter_sva.sv ***
// Concurrent checks on the core-side ports of the memory map and arbiter.
`timescale 1ns/10ps
module on_chip_memory_map_arbiter_sva #(
  parameter int SINGLE_ACCESS_RAM_BLOCKS = 2,
  parameter int SINGLE_ACCESS_RAM_BLOCK_WORDS = 1024
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic FETCH_REQ,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic READ_REQ,
  input wire logic [1:0] READ_SPACE,
  input wire logic [15:0] READ_ADDR,
  input wire logic WRITE_REQ,
  input wire logic [1:0] WRITE_SPACE,
  input wire logic [15:0] WRITE_ADDR,
  input wire logic EXTERNAL_ORIGIN,
  input wire logic NOT_READY,
  input wire logic ACCESS_DONE,
  input wire logic READ_ON_CHIP,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST
);
  logic [4:0] mode;
  logic [4:0] next_mode;
  logic rd_sa, wr_sa, ft_sa, rw_same, fr_same, rd_b1, wr_b1;
  function automatic logic sa(input logic [15:0] a);
    return a >= memory_map_pkg::SINGLE_ACCESS_RAM_BASE && a < memory_map_pkg::SINGLE_ACCESS_RAM_BASE + 16'(SINGLE_ACCESS_RAM_BLOCKS * SINGLE_ACCESS_RAM_BLOCK_WORDS);
  endfunction
  function automatic logic [15:0] blk(input logic [15:0] a);
    return (a - memory_map_pkg::SINGLE_ACCESS_RAM_BASE) / 16'(SINGLE_ACCESS_RAM_BLOCK_WORDS);
  endfunction
  // Mirror of the mode bits as reset and written over the bus, without the reset strap, since the map is invisible at the ports
  always_comb begin
    next_mode = mode;
    if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == memory_map_pkg::MODE_OFFSET && AVS_BYTEENABLE[0]) begin
      next_mode = AVS_WRITEDATA[4:0];
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode <= memory_map_pkg::MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end
  assign rd_sa = READ_REQ && READ_SPACE == memory_map_pkg::SPACE_LOCAL_DATA && sa(READ_ADDR) && mode[2];
  assign wr_sa = WRITE_REQ && WRITE_SPACE == memory_map_pkg::SPACE_LOCAL_DATA && sa(WRITE_ADDR) && mode[2];
  assign ft_sa = FETCH_REQ && sa(FETCH_ADDR) && mode[3];
  assign rw_same = rd_sa && wr_sa && blk(READ_ADDR) == blk(WRITE_ADDR);
  assign fr_same = ft_sa && rd_sa && blk(FETCH_ADDR) == blk(READ_ADDR);
  assign rd_b1 = READ_SPACE == memory_map_pkg::SPACE_LOCAL_DATA && READ_ADDR >= memory_map_pkg::B1_BASE
    && READ_ADDR < memory_map_pkg::B1_END;
  assign wr_b1 = WRITE_SPACE == memory_map_pkg::SPACE_LOCAL_DATA && WRITE_ADDR >= memory_map_pkg::B1_BASE
    && WRITE_ADDR < memory_map_pkg::B1_END;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_all_three;
    $rose(READ_REQ) && FETCH_REQ && WRITE_REQ && !ft_sa && !rd_sa && !wr_sa |=> ACCESS_DONE;
  endproperty
  a_all_three: assert property (p_all_three)
    else $error("three accesses not done in one cycle");
  property p_dual_rw;
    $rose(WRITE_REQ) && READ_REQ && !FETCH_REQ && rd_b1 && wr_b1 |=> ACCESS_DONE;
  endproperty
  a_dual_rw: assert property (p_dual_rw)
    else $error("dual ram read and write stalled");
  property p_rw_conflict;
    $rose(WRITE_REQ) && rw_same && !FETCH_REQ |=> !ACCESS_DONE ##1 ACCESS_DONE;
  endproperty
  a_rw_conflict: assert property (p_rw_conflict)
    else $error("single block served two accesses in one cycle");
  property p_not_ready;
    $rose(WRITE_REQ) && rw_same |=> NOT_READY;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("no stall on single block collision");
  property p_fetch_serial;
    $rose(FETCH_REQ) && fr_same && !WRITE_REQ |=> !ACCESS_DONE ##1 ACCESS_DONE;
  endproperty
  a_fetch_serial: assert property (p_fetch_serial)
    else $error("fetch and read of one block not two cycles");
  property p_three_way;
    $rose(FETCH_REQ) && fr_same && rw_same |=> !ACCESS_DONE [*2] ##1 ACCESS_DONE;
  endproperty
  a_three_way: assert property (p_three_way)
    else $error("three accesses to one block not three cycles");
  property p_parallel;
    $rose(WRITE_REQ) && rd_sa && wr_sa && !rw_same && !FETCH_REQ |=> ACCESS_DONE;
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("different single blocks not accessed in parallel");
  property p_off_space;
    ACCESS_DONE && $past(READ_REQ) && $past(READ_SPACE[1]) |-> !READ_ON_CHIP;
  endproperty
  a_off_space: assert property (p_off_space)
    else $error("io or global read served on chip");
  property p_protect;
    ACCESS_DONE && $past(READ_REQ) && $past(EXTERNAL_ORIGIN) && mode[4] |-> !READ_ON_CHIP;
  endproperty
  a_protect: assert property (p_protect)
    else $error("external instruction reached on-chip memory");
endmodule

// *** core_model.sv ***
// Behavioural processor core issuing fetch, read and write request sets.
`timescale 1ns/10ps
module core_model (
  input wire logic CLOCK,
  input wire logic ACCESS_DONE,
  output logic FETCH_REQ,
  output logic [15:0] FETCH_ADDR,
  output logic READ_REQ,
  output logic [1:0] READ_SPACE,
  output logic [15:0] READ_ADDR,
  output logic WRITE_REQ,
  output logic [1:0] WRITE_SPACE,
  output logic [15:0] WRITE_ADDR,
  output logic [15:0] WRITE_DATA
);
  initial begin
    {FETCH_REQ, READ_REQ, WRITE_REQ} = 3'h0;
    {FETCH_ADDR, READ_ADDR, WRITE_ADDR, WRITE_DATA, READ_SPACE, WRITE_SPACE} = '0;
  end
  task automatic issue(input logic [2:0] frw, input logic [15:0] fa, input logic [1:0] rs, input logic [15:0] ra,
                       input logic [15:0] wa, input logic [15:0] wd, output int n);
    n = 0;
    {FETCH_REQ, READ_REQ, WRITE_REQ} <= frw;
    FETCH_ADDR <= fa;
    READ_SPACE <= rs;
    READ_ADDR <= ra;
    WRITE_SPACE <= memory_map_pkg::SPACE_LOCAL_DATA;
    WRITE_ADDR <= wa;
    WRITE_DATA <= wd;
    // Completion is taken at the rising edge, and the set is released there
    do begin
      @(posedge CLOCK);
      n++;
    end while (ACCESS_DONE !== 1'b1 && n < 40);
    {FETCH_REQ, READ_REQ, WRITE_REQ} <= 3'h0;
    // Released address and data lines invert so a stale value never passes for a live one
    {FETCH_ADDR, READ_ADDR, WRITE_ADDR, WRITE_DATA} <= ~{fa, ra, wa, wd};
    @(posedge CLOCK);
  endtask
endmodule

// *** on_chip_memory_map_arbiter_tb.sv ***
// Self-checking testbench for the on-chip memory map and arbiter.
`timescale 1ns/10ps
module on_chip_memory_map_arbiter_tb;
  localparam logic [15:0] ROM_IMAGE = 16'h5a5a;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic ROM_SELECT_N = 1'b0;
  logic EXTERNAL_ORIGIN = 1'b0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic [3:0] AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic FETCH_REQ, READ_REQ, WRITE_REQ, NOT_READY, ACCESS_DONE, FETCH_ON_CHIP, READ_ON_CHIP, AVS_WAITREQUEST;
  logic [1:0] READ_SPACE, WRITE_SPACE;
  logic [15:0] FETCH_ADDR, READ_ADDR, WRITE_ADDR, WRITE_DATA, FETCH_DATA, READ_DATA;
  logic [31:0] AVS_READDATA, q;
  int num_errors = 0;
  int n_checks = 0;
  int n;
  initial forever #5 CLOCK = ~CLOCK;
  core_model u_core (.CLOCK(CLOCK), .ACCESS_DONE(ACCESS_DONE), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
    .READ_REQ(READ_REQ), .READ_SPACE(READ_SPACE), .READ_ADDR(READ_ADDR), .WRITE_REQ(WRITE_REQ),
    .WRITE_SPACE(WRITE_SPACE), .WRITE_ADDR(WRITE_ADDR), .WRITE_DATA(WRITE_DATA));
  on_chip_memory_map_arbiter #(.ROM_FILL(ROM_IMAGE), .SINGLE_ACCESS_RAM_BLOCKS(2), .SINGLE_ACCESS_RAM_BLOCK_WORDS(1024)) u_dut (
    .CLOCK(CLOCK), .RST(RST), .ROM_SELECT_N(ROM_SELECT_N), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
    .READ_REQ(READ_REQ), .READ_SPACE(READ_SPACE), .READ_ADDR(READ_ADDR), .WRITE_REQ(WRITE_REQ),
    .WRITE_SPACE(WRITE_SPACE), .WRITE_ADDR(WRITE_ADDR), .WRITE_DATA(WRITE_DATA), .EXTERNAL_ORIGIN(EXTERNAL_ORIGIN),
    .NOT_READY(NOT_READY), .ACCESS_DONE(ACCESS_DONE), .FETCH_DATA(FETCH_DATA), .FETCH_ON_CHIP(FETCH_ON_CHIP),
    .READ_DATA(READ_DATA), .READ_ON_CHIP(READ_ON_CHIP), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= 4'hf;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    // Waitrequest and read data are both taken at the same rising edge
    do begin
      @(posedge CLOCK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 40);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    chk("bus wait", 32'h0, 32'(k / 40));
    if (k == 40) tally_and_finish();
    @(posedge CLOCK);
  endtask
  task automatic core(input logic [2:0] frw, input logic [15:0] fa, input logic [1:0] rs, input logic [15:0] ra,
                      input logic [15:0] wa, input logic [15:0] wd, input int cyc);
    u_core.issue(frw, fa, rs, ra, wa, wd, n);
    chk("cycles", 32'(cyc + 1), 32'(n));
    if (n >= 40) tally_and_finish();
  endtask
  initial begin
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (5) @(posedge CLOCK);
    bus(1'b0, 4'h0, 32'h0);
    chk("mode", 32'h04, q);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, q);
    core(3'h4, 16'h0010, 2'h1, 16'h0, 16'h0, 16'h0, 1);
    chk("rom", {1'b1, ROM_IMAGE}, {FETCH_ON_CHIP, FETCH_DATA});
    bus(1'b1, 4'h0, 32'h05);
    core(3'h4, 16'h0010, 2'h1, 16'h0, 16'h0, 16'h0, 1);
    chk("rom removed", 1'b0, FETCH_ON_CHIP);
    $display("test boot rom done");
    bus(1'b1, 4'h0, 32'h04);
    core(3'h5, 16'h0010, 2'h1, 16'h0, 16'h0060, 16'hbeef, 1);
    core(3'h7, 16'h0010, 2'h1, 16'h0060, 16'h0400, 16'h1234, 1);
    chk("block two", {1'b1, 16'hbeef}, {READ_ON_CHIP, READ_DATA});
    core(3'h3, 16'h0, 2'h1, 16'h0400, 16'h0401, 16'h0ab0, 1);
    chk("block one", {1'b1, 16'h1234}, {READ_ON_CHIP, READ_DATA});
    for (int s = 2; s < 4; s++) begin
      core(3'h2, 16'h0, 2'(s), 16'h0400, 16'h0, 16'h0, 1);
      chk("io global", 1'b0, READ_ON_CHIP);
    end
    core(3'h1, 16'h0, 2'h1, 16'h0, 16'h0100, 16'h7777, 1);
    bus(1'b1, 4'h0, 32'h06);
    core(3'h6, 16'hfe00, 2'h1, 16'h0100, 16'h0, 16'h0, 1);
    chk("block zero", {1'b1, 16'h7777, 1'b0}, {FETCH_ON_CHIP, FETCH_DATA, READ_ON_CHIP});
    $display("test dual ram done");
    bus(1'b1, 4'h0, 32'h0c);
    core(3'h3, 16'h0, 2'h1, 16'h0c00, 16'h0800, 16'h1111, 1);
    core(3'h3, 16'h0, 2'h1, 16'h0800, 16'h0800, 16'h2222, 2);
    chk("write first", 16'h2222, READ_DATA);
    core(3'h6, 16'h0800, 2'h1, 16'h0800, 16'h0, 16'h0, 2);
    chk("shared", {16'h2222, 16'h2222}, {FETCH_DATA, READ_DATA});
    core(3'h7, 16'h0800, 2'h1, 16'h0800, 16'h0800, 16'h3333, 3);
    chk("three way", {16'h3333, 16'h3333}, {FETCH_DATA, READ_DATA});
    bus(1'b1, 4'h0, 32'h04);
    core(3'h6, 16'h0800, 2'h1, 16'h0800, 16'h0, 16'h0, 1);
    chk("data only", 2'h1, {FETCH_ON_CHIP, READ_ON_CHIP});
    bus(1'b1, 4'h0, 32'h08);
    core(3'h6, 16'h0800, 2'h1, 16'h0800, 16'h0, 16'h0, 1);
    chk("program only", 2'h2, {FETCH_ON_CHIP, READ_ON_CHIP});
    $display("test single ram done");
    bus(1'b1, 4'h0, 32'h14);
    EXTERNAL_ORIGIN <= 1'b1;
    core(3'h3, 16'h0, 2'h1, 16'h0400, 16'h0400, 16'hdead, 1);
    chk("blocked", 17'h0, {READ_ON_CHIP, READ_DATA});
    EXTERNAL_ORIGIN <= 1'b0;
    core(3'h2, 16'h0, 2'h1, 16'h0400, 16'h0, 16'h0, 1);
    chk("write dropped", {1'b1, 16'h1234}, {READ_ON_CHIP, READ_DATA});
    bus(1'b0, 4'h4, 32'h0);
    chk("status blocked", 32'h1, q);
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk("status cleared", 32'h0, q);
    $display("test protection done");
    ROM_SELECT_N <= 1'b1;
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (5) @(posedge CLOCK);
    bus(1'b0, 4'h0, 32'h0);
    chk("mode strap high", 32'h05, q);
    bus(1'b0, 4'h4, 32'h0);
    chk("status strap high", 32'h4, q);
    core(3'h4, 16'h0010, 2'h1, 16'h0, 16'h0, 16'h0, 1);
    chk("rom off at strap high", 1'b0, FETCH_ON_CHIP);
    $display("test reset strap done");
    tally_and_finish();
  end
endmodule
bind on_chip_memory_map_arbiter on_chip_memory_map_arbiter_sva #(.SINGLE_ACCESS_RAM_BLOCKS(SINGLE_ACCESS_RAM_BLOCKS),
  .SINGLE_ACCESS_RAM_BLOCK_WORDS(SINGLE_ACCESS_RAM_BLOCK_WORDS)) u_sva (.CLOCK(CLOCK), .RST(RST), .FETCH_REQ(FETCH_REQ),
  .FETCH_ADDR(FETCH_ADDR), .READ_REQ(READ_REQ), .READ_SPACE(READ_SPACE), .READ_ADDR(READ_ADDR),
  .WRITE_REQ(WRITE_REQ), .WRITE_SPACE(WRITE_SPACE), .WRITE_ADDR(WRITE_ADDR), .EXTERNAL_ORIGIN(EXTERNAL_ORIGIN),
  .NOT_READY(NOT_READY), .ACCESS_DONE(ACCESS_DONE), .READ_ON_CHIP(READ_ON_CHIP), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST));
